// file: fsoac_pkg.sv
package fsoac_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // opcodes handled by this block
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_OTP_READ = 8'h48;
  localparam logic [7:0] OP_OTP_ERASE = 8'h44;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  // frame lengths in bits
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_END_BITS = 32;
  localparam int DUMMY_END_BITS = 40;
  // status byte layout
  localparam int ST_WIP_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_LOCK_LSB = 2;
  // otp area addressing
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int AREA_BYTES = 256;
  // timing, least times round up, longest times round down
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int WAKE_TIME_NS = 3000;
  localparam int WAKE_WITH_ID_TIME_NS = 1800;
  localparam int SECTOR_ERASE_TIME_NS = 2000000;
  localparam int PAGE_PROGRAM_TIME_NS = 700000;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_ID_CYC = (WAKE_WITH_ID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYC = (SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_CYC = (PAGE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host link clock: half period in system cycles, idle gap after select rises
  localparam int SCLK_HALF_CYC = 8;
  localparam int CS_GAP_CYC = 2;
  typedef enum logic [1:0] {PWR_AWAKE, PWR_ENTERING, PWR_ASLEEP, PWR_WAKING} fsoac_pwr_type;
  typedef enum logic [1:0] {JOB_NONE, JOB_ERASE, JOB_PROG} fsoac_job_type;
  typedef enum logic [2:0] {
    CMD_SLEEP, CMD_WAKE, CMD_READ_ID, CMD_OTP_READ,
    CMD_OTP_ERASE, CMD_OTP_PROG, CMD_WREN, CMD_STATUS
  } fsoac_cmd_type;
  typedef enum logic [2:0] {H_IDLE, H_LO, H_HI, H_END, H_GAP} fsoac_hstate_type;
endpackage

// file: fsoac_if.sv
`timescale 1ns/1ps
interface fsoac_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  modport host (output cs_n, output sclk, output si, input so, input so_oe);
  modport dev (input cs_n, input sclk, input si, output so, output so_oe);
endinterface

// file: fsoac_dev.sv
`timescale 1ns/1ps
// Summary of operation
// R1: sleep opcode B9h, executes only on exactly 8 bits
// R2: sleep state reached within entry time
// R3: asleep, only ABh recognised, all else ignored
// R4: reset always starts awake in standby
// R5: ABh alone wakes after wake time
// R6: ABh plus three dummies returns ID MSB-first
// R7: ID repeats until select rises
// R8: ID form wakes after shorter wake time
// R9: ABh ignored while write in progress
// R10: 48h, address, dummy, then area data out
// R11: read address increments, bits 9..0 wrap
// R12: three 256-byte areas, middle byte selects
// R13: host sets write enable before erase
// R14: erase executes only on exact length
// R15: erase self-timed, busy flag, latch cleared
// R16: locked areas never erased, lock sticky
// R17: 42h, address, 1..256 data bytes
// R18: program self-timed, busy flag, latch cleared
// R19: locked areas never programmed
// R20: short frames abort without side effects; a 42h opcode during a program job clears pmask, so it writes nothing
module fsoac_dev
  import fsoac_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5A, // arbitrary identification value
  parameter int ERASE_CYC = SECTOR_ERASE_CYC,
  parameter int PROG_CYC = PAGE_PROGRAM_CYC
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  fsoac_if.dev spi, // serial link pins
  input wire logic [2:0] lock_set_i, // sets area lock bits, sticky
  output logic wip_o, // write in progress flag
  output logic wel_o, // write enable latch
  output logic asleep_o, // deep sleep state
  output logic [2:0] lock_o // area lock bits
);
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] ck_s;
    logic [1:0] si_s;
    logic ck_prev;
    logic cs_prev;
    logic [15:0] bits;
    logic [7:0] op;
    logic [7:0] sh;
    logic [23:0] addr;
    logic [7:0] tx;
    logic so;
    fsoac_pwr_type pwr;
    logic [15:0] ptimer;
    fsoac_job_type job;
    logic [1:0] jarea;
    logic [31:0] btimer;
    logic write_enable_latch;
    logic [2:0] lock;
    logic [255:0] pmask;
  } fsoac_dev_state_type;

  fsoac_dev_state_type q, d;
  logic [7:0] mem [0:1023];
  logic [7:0] pbuf [0:AREA_BYTES-1];
  logic ck_rise, ck_fall, sel_fall, sel_rise, out_ph;
  logic [15:0] nbits;
  logic [7:0] byte_in, byte_out;
  logic pb_we, cm_erase, cm_prog;

  // address must sit in one of the three areas, top byte zero
  function automatic logic area_ok(input logic [23:0] a, input logic [2:0] lk);
    area_ok = (a[23:10] == 14'h0000) && (a[9:8] != 2'h0) && !lk[a[9:8] - 2'h1];
  endfunction

  // which opcodes are heard depends on power and busy state
  function automatic logic accept(input logic [7:0] o, input fsoac_pwr_type p,
                                  input fsoac_job_type j);
    accept = 1'b0;
    if (p == PWR_ASLEEP) begin
      accept = (o == OP_WAKE_ID); // R3
    end else if (p == PWR_AWAKE && j != JOB_NONE) begin
      accept = (o == OP_STATUS); // R9
    end else if (p == PWR_AWAKE) begin
      accept = (o == OP_SLEEP) || (o == OP_WAKE_ID) || (o == OP_OTP_READ) ||
               (o == OP_OTP_ERASE) || (o == OP_OTP_PROG) || (o == OP_WREN) ||
               (o == OP_STATUS);
    end
  endfunction

  always_comb begin
    d = q;
    // synchronisers: only the second stage is looked at
    d.cs_s = {q.cs_s[0], spi.cs_n};
    d.ck_s = {q.ck_s[0], spi.sclk};
    d.si_s = {q.si_s[0], spi.si};
    d.ck_prev = q.ck_s[1];
    d.cs_prev = q.cs_s[1];
    d.lock = q.lock | lock_set_i; // R16
    ck_rise = q.ck_s[1] & ~q.ck_prev & ~q.cs_s[1];
    ck_fall = ~q.ck_s[1] & q.ck_prev & ~q.cs_s[1];
    sel_fall = ~q.cs_s[1] & q.cs_prev;
    sel_rise = q.cs_s[1] & ~q.cs_prev;
    nbits = (q.bits == 16'hFFFF) ? q.bits : q.bits + 16'h0001;
    byte_in = {q.sh[6:0], q.si_s[1]};
    out_ph = ((q.op == OP_WAKE_ID) && (q.bits >= 16'(ADDR_END_BITS))) ||
             ((q.op == OP_OTP_READ) && (q.bits >= 16'(DUMMY_END_BITS))) ||
             ((q.op == OP_STATUS) && (q.bits >= 16'(OPCODE_BITS)));
    pb_we = 1'b0;
    cm_erase = 1'b0;
    cm_prog = 1'b0;
    byte_out = DEV_ID; // R7
    if (q.op == OP_STATUS) begin
      byte_out = 8'h00;
      byte_out[ST_WIP_BIT] = (q.job != JOB_NONE);
      byte_out[ST_WEL_BIT] = q.write_enable_latch;
      byte_out[ST_LOCK_LSB +: 3] = q.lock;
    end else if (q.op == OP_OTP_READ) begin
      byte_out = area_ok(q.addr, 3'h0) ? mem[q.addr[9:0]] : ERASED_BYTE; // R12
    end

    // new frame: forget the previous opcode and count
    if (sel_fall) begin
      d.bits = 16'h0000;
      d.op = OP_NONE;
    end

    // input bits are taken on rising link clock
    if (ck_rise) begin
      d.sh = byte_in;
      d.bits = nbits;
      if (nbits == 16'(OPCODE_BITS)) begin
        d.op = accept(byte_in, q.pwr, q.job) ? byte_in : OP_NONE; // R3 R9
        if (byte_in == OP_OTP_PROG) begin
          d.pmask = '0;
        end
      end else if ((q.op == OP_OTP_READ || q.op == OP_OTP_ERASE || q.op == OP_OTP_PROG) &&
                   nbits[2:0] == 3'h0 && nbits <= 16'(ADDR_END_BITS)) begin
        d.addr = {q.addr[15:0], byte_in}; // R10
      end else if (q.op == OP_OTP_PROG && nbits[2:0] == 3'h0) begin
        // data beyond 256 bytes wraps and overwrites inside the buffer
        pb_we = 1'b1; // R17
        d.pmask[q.addr[7:0]] = 1'b1;
        d.addr[7:0] = q.addr[7:0] + 8'h01;
      end
    end

    // output bits change on falling link clock, a fresh byte on each boundary
    if (ck_fall && out_ph) begin
      if (q.bits[2:0] == 3'h0) begin
        d.so = byte_out[7]; // R6
        d.tx = {byte_out[6:0], 1'b0};
        if (q.op == OP_OTP_READ) begin
          d.addr[9:0] = q.addr[9:0] + 10'h001; // R11
        end
      end else begin
        d.so = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end
    end

    // power state timers
    unique case (q.pwr)
      PWR_ENTERING: begin
        if (q.ptimer == 16'h0000) d.pwr = PWR_ASLEEP; // R2
        else d.ptimer = q.ptimer - 16'h0001;
      end
      PWR_WAKING: begin
        if (q.ptimer == 16'h0000) d.pwr = PWR_AWAKE; // R5 R8
        else d.ptimer = q.ptimer - 16'h0001;
      end
      PWR_AWAKE: begin
      end
      PWR_ASLEEP: begin
      end
    endcase

    // self-timed erase or program, applied to the array at the end
    if (q.job != JOB_NONE) begin
      if (q.btimer == 32'h0) begin
        cm_erase = (q.job == JOB_ERASE); // R15
        cm_prog = (q.job == JOB_PROG); // R18
        d.job = JOB_NONE;
      end else begin
        d.btimer = q.btimer - 32'h1;
      end
    end

    // select rising executes the command only on a valid length: exact, or whole bytes past the header for ID and program
    if (sel_rise) begin
      if (q.op == OP_SLEEP && q.bits == 16'(OPCODE_BITS)) begin
        d.pwr = PWR_ENTERING; // R1 R20
        // synchroniser lag comes out of the budget so the limit holds at the pin
        d.ptimer = 16'(SLEEP_ENTRY_CYC - 4);
      end else if (q.op == OP_WAKE_ID && q.pwr == PWR_ASLEEP) begin
        if (q.bits == 16'(OPCODE_BITS)) begin
          d.pwr = PWR_WAKING; // R5
          d.ptimer = 16'(WAKE_CYC - 1);
        end else if (q.bits >= 16'(ADDR_END_BITS) && q.bits[2:0] == 3'h0) begin
          d.pwr = PWR_WAKING; // R8
          d.ptimer = 16'(WAKE_ID_CYC - 1);
        end
      end else if (q.op == OP_WREN && q.bits == 16'(OPCODE_BITS)) begin
        d.write_enable_latch = 1'b1;
      end else if (q.op == OP_OTP_ERASE && q.bits == 16'(ADDR_END_BITS) && q.write_enable_latch &&
                   area_ok(q.addr, q.lock)) begin
        d.job = JOB_ERASE; // R14 R16
        d.jarea = q.addr[9:8];
        d.btimer = 32'(ERASE_CYC - 1);
        d.write_enable_latch = 1'b0; // R15
      end else if (q.op == OP_OTP_PROG && q.bits >= 16'(DUMMY_END_BITS) &&
                   q.bits[2:0] == 3'h0 && q.write_enable_latch && area_ok(q.addr, q.lock)) begin
        d.job = JOB_PROG; // R19
        d.jarea = q.addr[9:8];
        d.btimer = 32'(PROG_CYC - 1);
        d.write_enable_latch = 1'b0; // R18
      end
    end
  end

  // state register; reset leaves the part awake and idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs_s <= 2'h3;
      q.cs_prev <= 1'b1;
      q.pwr <= PWR_AWAKE; // R4
      q.job <= JOB_NONE;
    end else begin
      q <= d;
    end
  end

  // program buffer holds data until the frame is known good
  always_ff @(posedge sys_clk_i) begin
    if (pb_we) begin
      pbuf[q.addr[7:0]] <= byte_in;
    end
  end

  // otp array; reset stands in for the erased factory state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 1024; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else begin
      for (int i = 0; i < AREA_BYTES; i++) begin
        if (cm_erase) begin
          mem[{q.jarea, 8'(i)}] <= ERASED_BYTE;
        end else if (cm_prog && q.pmask[i]) begin
          mem[{q.jarea, 8'(i)}] <= mem[{q.jarea, 8'(i)}] & pbuf[i]; // bits only go to 0
        end
      end
    end
  end

  assign spi.so = q.so;
  assign spi.so_oe = ~q.cs_s[1] & out_ph;
  assign wip_o = (q.job != JOB_NONE);
  assign wel_o = q.write_enable_latch;
  assign asleep_o = (q.pwr == PWR_ASLEEP);
  assign lock_o = q.lock;
endmodule

// file: fsoac_host.sv
`timescale 1ns/1ps
module fsoac_host
  import fsoac_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  fsoac_if.host spi, // serial link pins
  input wire logic cmd_valid_i, // start a command
  input fsoac_cmd_type cmd_i, // command kind
  input wire logic [23:0] addr_i, // otp address
  input wire logic [8:0] len_i, // data bytes, 1..256
  input wire logic [7:0] wr_data_i, // program byte, taken with data_req_o
  output logic cmd_ready_o, // idle, command accepted
  output logic data_req_o, // program byte taken this cycle
  output logic [7:0] rd_data_o, // received byte
  output logic rd_valid_o // rd_data_o valid, one cycle
);
  typedef struct packed {
    fsoac_hstate_type st;
    logic [1:0] so_s;
    logic [7:0] op;
    logic [23:0] addr;
    logic [12:0] hdr_bits;
    logic [12:0] tot;
    logic [12:0] bc;
    logic [15:0] cnt;
    logic [15:0] gap;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rdata;
    logic rvalid;
    logic is_prog;
    logic is_read;
    logic cs_n;
    logic sclk;
    logic si;
  } fsoac_host_state_type;

  fsoac_host_state_type q, d;
  logic [12:0] nbc;
  logic [9:0] idx;
  logic [7:0] nb;
  logic [12:0] dbits;

  always_comb begin
    d = q;
    d.so_s = {q.so_s[0], spi.so};
    d.rvalid = 1'b0;
    nbc = q.bc + 13'h0001;
    idx = q.bc[12:3];
    dbits = {1'b0, (len_i == 9'h000) ? 9'h001 : len_i, 3'h0};
    data_req_o = 1'b0;
    // byte that goes out next: opcode, address, then dummy or data
    nb = 8'h00;
    if (idx == 10'h001) nb = q.addr[23:16];
    else if (idx == 10'h002) nb = q.addr[15:8];
    else if (idx == 10'h003) nb = q.addr[7:0];
    else if (idx >= 10'h004 && q.is_prog) nb = wr_data_i; // R17
    unique case (q.st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          d.st = H_LO;
          d.cs_n = 1'b0;
          d.bc = '0;
          d.cnt = 16'(SCLK_HALF_CYC - 1);
          d.addr = addr_i;
          d.is_prog = (cmd_i == CMD_OTP_PROG);
          d.is_read = (cmd_i == CMD_READ_ID) || (cmd_i == CMD_OTP_READ) ||
                      (cmd_i == CMD_STATUS);
          d.gap = 16'(CS_GAP_CYC);
          d.hdr_bits = 13'(OPCODE_BITS);
          d.tot = 13'(OPCODE_BITS); // R1 R14
          unique case (cmd_i)
            CMD_SLEEP: d.op = OP_SLEEP;
            CMD_WAKE: begin
              d.op = OP_WAKE_ID;
              d.gap = 16'(WAKE_CYC); // R5
            end
            CMD_READ_ID: begin
              d.op = OP_WAKE_ID;
              d.hdr_bits = 13'(ADDR_END_BITS); // R6
              d.tot = 13'(ADDR_END_BITS) + dbits;
              d.gap = 16'(WAKE_ID_CYC); // R8
            end
            CMD_OTP_READ: begin
              d.op = OP_OTP_READ;
              d.hdr_bits = 13'(DUMMY_END_BITS); // R10
              d.tot = 13'(DUMMY_END_BITS) + dbits;
            end
            CMD_OTP_ERASE: begin
              d.op = OP_OTP_ERASE;
              d.tot = 13'(ADDR_END_BITS); // R14
            end
            CMD_OTP_PROG: begin
              d.op = OP_OTP_PROG;
              d.hdr_bits = 13'(ADDR_END_BITS);
              d.tot = 13'(ADDR_END_BITS) + dbits; // R17
            end
            CMD_WREN: d.op = OP_WREN; // R13
            CMD_STATUS: begin
              d.op = OP_STATUS;
              d.tot = 13'(OPCODE_BITS) + dbits;
            end
          endcase
          d.si = d.op[7];
          d.tx = {d.op[6:0], 1'b0};
        end
      end
      // clock low: at the end raise the clock and sample the return line
      H_LO: begin
        if (q.cnt == 16'h0000) begin
          d.sclk = 1'b1;
          d.bc = nbc;
          d.rx = {q.rx[6:0], q.so_s[1]};
          if (q.is_read && nbc[2:0] == 3'h0 && nbc > q.hdr_bits) begin
            d.rdata = {q.rx[6:0], q.so_s[1]};
            d.rvalid = 1'b1;
          end
          d.cnt = 16'(SCLK_HALF_CYC - 1);
          d.st = H_HI;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      // clock high: at the end drop the clock and present the next bit
      H_HI: begin
        if (q.cnt == 16'h0000) begin
          d.sclk = 1'b0;
          d.cnt = 16'(SCLK_HALF_CYC - 1);
          if (q.bc == q.tot) begin
            d.st = H_END;
          end else begin
            d.st = H_LO;
            if (q.bc[2:0] == 3'h0) begin
              data_req_o = q.is_prog && (idx >= 10'h004);
              d.si = nb[7];
              d.tx = {nb[6:0], 1'b0};
            end else begin
              d.si = q.tx[7];
              d.tx = {q.tx[6:0], 1'b0};
            end
          end
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      // select rises half a link period after the last falling clock, then stays high through the gap
      H_END: begin
        if (q.cnt == 16'h0000) begin
          d.cs_n = 1'b1; // R1 R14
          d.cnt = q.gap;
          d.st = H_GAP;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      H_GAP: begin
        if (q.cnt == 16'h0000) d.st = H_IDLE; // R5 R8
        else d.cnt = q.cnt - 16'h0001;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= H_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign spi.cs_n = q.cs_n;
  assign spi.sclk = q.sclk;
  assign spi.si = q.si;
  assign cmd_ready_o = (q.st == H_IDLE);
  assign rd_data_o = q.rdata;
  assign rd_valid_o = q.rvalid;
endmodule

// file: fsoac_sva.sv
`timescale 1ns/1ps
module fsoac_sva
  import fsoac_pkg::*;
#(
  parameter int ERASE_CYC = SECTOR_ERASE_CYC,
  parameter int PROG_CYC = PAGE_PROGRAM_CYC
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // async reset
  input wire logic cs_n, // select, low active
  input wire logic sclk, // link clock
  input wire logic so, // device data
  input wire logic so_oe, // device drives so
  input wire logic wip_o, // write in progress
  input wire logic wel_o, // write enable latch
  input wire logic asleep_o, // deep sleep state
  input wire logic [2:0] lock_o // area locks
);
  logic cs_q;
  logic [7:0] since_rise_q;
  logic [15:0] busy_cnt_q;

  // cycles since select rose, saturating so that long idle spans never wrap
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_q <= 1'b1;
      since_rise_q <= 8'hFF;
      busy_cnt_q <= 16'h0000;
    end else begin
      cs_q <= cs_n;
      if (cs_n && !cs_q) since_rise_q <= 8'h00;
      else if (since_rise_q != 8'hFF) since_rise_q <= since_rise_q + 8'h01;
      busy_cnt_q <= wip_o ? busy_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // sequences: the select stays high for 8 cycles, and a self-timed job starts
  sequence s_cs_idle;
    cs_n [*8];
  endsequence
  sequence s_busy_start;
    $rose(wip_o);
  endsequence

  // the synchroniser lag is why a few cycles of slack are allowed below
  chk_so_idle_off: assert property (s_cs_idle |-> !so_oe)
    else $error("so driven while deselected");
  chk_so_on_fall: assert property (so_oe && $rose(sclk) |-> $stable(so))
    else $error("so moved at a rising link edge");
  chk_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock not low between frames");
  chk_sleep_entry: assert property ($rose(asleep_o) |->
    since_rise_q >= SLEEP_ENTRY_CYC - 8 && since_rise_q < SLEEP_ENTRY_CYC)
    else $error("sleep reached at the wrong time");
  chk_wake_edge: assert property ($fell(asleep_o) |-> since_rise_q <= 8'h0A)
    else $error("wake not tied to a frame end");
  chk_busy_start: assert property (s_busy_start |->
    since_rise_q >= 8'h01 && since_rise_q <= 8'h0A)
    else $error("busy not started by select rise");
  chk_busy_wel: assert property (s_busy_start |-> ##[0:2] !wel_o)
    else $error("write enable not cleared by job");
  chk_busy_length: assert property ($fell(wip_o) |->
    (busy_cnt_q == ERASE_CYC || busy_cnt_q == PROG_CYC))
    else $error("busy span has the wrong length");
  chk_busy_awake: assert property (wip_o |-> !asleep_o)
    else $error("sleep entered during a job");
  chk_lock_sticky: assert property (($past(lock_o) & ~lock_o) == 3'h0)
    else $error("lock bit cleared");
endmodule

// file: flash_sleep_and_otp_area_cmds_tb.sv
`timescale 1ns/1ps
module flash_sleep_and_otp_area_cmds_tb;
  import fsoac_pkg::*;
  localparam int ECYC = 50;
  localparam int PCYC = 30;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identification value
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  fsoac_cmd_type cmd_i = CMD_WREN;
  logic [23:0] addr_i = 24'h000000;
  logic [8:0] len_i = 9'h001;
  logic [7:0] wr_data_i = 8'h00;
  logic [2:0] lock_set_i = 3'h0;
  logic cmd_ready_o, data_req_o, rd_valid_o, wip_o, wel_o, asleep_o, wip2, wel2, asleep2;
  logic [7:0] rd_data_o;
  logic [2:0] lock_o, lock2;
  int n_errors = 0;
  int total_checks = 0;
  logic [7:0] mem [3][256];
  logic [7:0] rq [$];
  logic [7:0] pd [$];
  logic [47:0] fb [8] = '{48'hB90000000000, 48'hB90000000000, 48'hB90000000000,
    48'hAB0000000000, 48'h060000000000, 48'h440001000000, 48'h440001000000, 48'h440001000000};
  int fn [8] = '{7, 9, 8, 8, 8, 24, 40, 32};
  logic [1:0] fx [8] = '{2'b00, 2'b00, 2'b10, 2'b00, 2'b01, 2'b01, 2'b01, 2'b00};
  fsoac_if bus ();
  fsoac_if bus2 ();

  fsoac_host u_fsoac_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi(bus), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .addr_i(addr_i), .len_i(len_i), .wr_data_i(wr_data_i),
    .cmd_ready_o(cmd_ready_o), .data_req_o(data_req_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o));
  fsoac_dev #(.DEV_ID(ID), .ERASE_CYC(ECYC), .PROG_CYC(PCYC)) u_fsoac_dev (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .spi(bus), .lock_set_i(lock_set_i), .wip_o(wip_o), .wel_o(wel_o),
    .asleep_o(asleep_o), .lock_o(lock_o));
  // second device faces a bench driver that sends frames of wrong and of exact length
  fsoac_dev #(.DEV_ID(ID), .ERASE_CYC(ECYC), .PROG_CYC(PCYC)) u_fsoac_dev2 (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .spi(bus2), .lock_set_i(3'h0), .wip_o(wip2), .wel_o(wel2),
    .asleep_o(asleep2), .lock_o(lock2));
  fsoac_sva #(.ERASE_CYC(ECYC), .PROG_CYC(PCYC)) u_fsoac_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .cs_n(bus.cs_n), .sclk(bus.sclk), .so(bus.so), .so_oe(bus.so_oe), .wip_o(wip_o),
    .wel_o(wel_o), .asleep_o(asleep_o), .lock_o(lock_o));

  initial begin
    bus2.cs_n = 1'b1;
    bus2.sclk = 1'b0;
    bus2.si = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
  end

  // gather read bytes, and keep the next program byte ready ahead of its request
  always @(posedge sys_clk_i) begin
    if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    if (data_req_o === 1'b1 && pd.size() > 0) begin
      void'(pd.pop_front());
      if (pd.size() > 0) wr_data_i <= pd[0];
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one host command, waiting for the host to return to idle
  task automatic run(input fsoac_cmd_type c, input logic [23:0] a, input int n);
    @(posedge sys_clk_i);
    if (pd.size() > 0) wr_data_i <= pd[0];
    cmd_i <= c;
    addr_i <= a;
    len_i <= n[8:0];
    cmd_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    @(negedge sys_clk_i);
    while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
  endtask

  // count the busy span; zero means the job was refused
  task automatic busy(input int n);
    int k, c;
    k = 0;
    c = 0;
    while (wip_o !== 1'b1 && k < 40) begin @(negedge sys_clk_i); k++; end
    while (wip_o === 1'b1 && c < 9000) begin @(negedge sys_clk_i); c++; end
    chk("busy cycles", n[7:0], c[7:0]);
  endtask

  function automatic logic [7:0] model(input logic [9:0] a);
    return (a[9:8] == 2'b00) ? 8'hFF : mem[a[9:8] - 2'b01][a[7:0]];
  endfunction

  task automatic readback(input logic [9:0] a, input int n);
    rq.delete();
    run(CMD_OTP_READ, {14'h0000, a}, n);
    chk("read count", n[7:0], 8'(rq.size()));
    for (int i = 0; i < n && i < rq.size(); i++) chk("otp byte", model(a + i), rq[i]);
  endtask

  // bit-banged frame of any length; a 480 ns link period keeps the device sampler happy
  task automatic raw(input logic [47:0] b, input int n);
    @(posedge sys_clk_i) bus2.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      bus2.si <= b[47 - i];
      repeat (6) @(posedge sys_clk_i);
      bus2.sclk <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      bus2.sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    bus2.cs_n <= 1'b1;
    repeat (SLEEP_ENTRY_CYC + 10) @(negedge sys_clk_i);
  endtask

  initial begin
    logic [7:0] d;
    void'($urandom(61087));
    foreach (mem[i, j]) mem[i][j] = 8'hFF;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk("reset state", 8'h00, {1'b0, asleep_o, wel_o, wip_o, lock_o, 1'b0});
    rq.delete();
    run(CMD_READ_ID, 24'h000000, 3);
    chk("id count", 8'h03, 8'(rq.size()));
    foreach (rq[i]) chk("device id", ID, rq[i]);
    $display("test id read done");
    // program across the area end so the byte pointer wraps inside it
    run(CMD_WREN, 24'h000000, 1);
    chk("wel set", 8'h01, {7'h00, wel_o});
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom());
      pd.push_back(d);
      mem[2][8'(8'hFE + i)] &= d;
    end
    run(CMD_OTP_PROG, 24'h0003FE, 3);
    busy(PCYC);
    chk("wel after program", 8'h00, {7'h00, wel_o});
    readback(10'h3FE, 4);
    readback(10'h300, 1);
    $display("test program and read done");
    @(posedge sys_clk_i) lock_set_i <= 3'b100;
    @(posedge sys_clk_i) lock_set_i <= 3'b000;
    run(CMD_WREN, 24'h000000, 1);
    pd.push_back(8'h00);
    run(CMD_OTP_PROG, 24'h000310, 1);
    busy(0);
    run(CMD_OTP_ERASE, 24'h000300, 0);
    busy(0);
    chk("locks and wel", 8'h09, {4'h0, lock_o, wel_o});
    readback(10'h30F, 3);
    $display("test locked area done");
    d = 8'($urandom());
    pd.push_back(d);
    mem[0][5] &= d;
    run(CMD_OTP_PROG, 24'h000105, 1);
    busy(PCYC);
    readback(10'h105, 1);
    run(CMD_WREN, 24'h000000, 1);
    run(CMD_OTP_ERASE, 24'h0001AA, 0);
    busy(ECYC);
    // the latch was spent by that erase, so this one must be refused
    run(CMD_OTP_ERASE, 24'h000200, 0);
    busy(0);
    foreach (mem[0][j]) mem[0][j] = 8'hFF;
    readback(10'h104, 3);
    $display("test erase done");
    for (int w = 0; w < 2; w++) begin
      run(CMD_SLEEP, 24'h000000, 1);
      repeat (SLEEP_ENTRY_CYC + 8) @(negedge sys_clk_i);
      chk("asleep", 8'h01, {7'h00, asleep_o});
      run(CMD_WREN, 24'h000000, 1);
      chk("wel while asleep", w[7:0], {7'h00, wel_o});
      rq.delete();
      run(w ? CMD_READ_ID : CMD_WAKE, 24'h000000, 1);
      chk("awake", 8'h00, {7'h00, asleep_o});
      if (w) chk("wake id", ID, rq[0]);
      run(CMD_WREN, 24'h000000, 1);
      rq.delete();
      run(CMD_STATUS, 24'h000000, 1);
      chk("status", {3'b000, 3'b100, 1'b1, 1'b0}, rq[0]);
    end
    $display("test sleep and wake done");
    for (int i = 0; i < 8; i++) begin
      raw(fb[i], fn[i]);
      chk("raw frame", {6'h00, fx[i]}, {6'h00, asleep2, wel2});
    end
    $display("test frame length done");
    end_of_test();
  end

  initial begin
    #(CLK_PERIOD_NS * 60000);
    n_errors++;
    end_of_test();
  end
endmodule
